// ===== src/spm_pkg.sv
// Purpose: shared constants for the special function pin multiplexer
// Assumes: 56-bit pin word, 200 MHz system clock
// Notes: bit positions are word indices, port n starts at 8*n
//
// Behaviour
// - port zero pins 0..7 map to word bits 0..7, pin n to bit n.
// - ports one to five take the next eight bits each, in order.
// - pins of an active function ignore generic port writes.
// - two-wire mode puts clock on port1 bit7, data on bit5, open drain.
// - two-wire master gets pin readback for arbitration and stretching.
// - a two-wire enable flag turns off both pin pull-ups.
// - display mode takes port four bits 0..4 and port three bits 0..7.
// - display power line low while enabled, high when off or suspended.
// - display chip selects on port four bits 5,6 stay generic pins.
// - a display enable flag turns off pull-ups on display pins.
// - serial peripheral master clock passes straight, up to 8 MHz.
// - peripheral mode takes port five bits 0..4 as clk,sel,mosi,rdy,miso.
// - default clk/mosi push-pull, sel open drain pulled, rdy pulled, miso hi-z.
// - option makes sel/mosi/clk open drain, rdy/miso hi-z, no pull-ups.
// - led mode takes port one bits 3..0 as enable, strobe, clock, data.
// - in suspend the active-low led enable is driven high.
// - key mode rows on port zero unpulled, driven low one at a time.
// - key matrix scanned every 4 ms, changes debounced over 16 ms.
// - in suspend key lines are pulled high; key closure never wakes.
// - generic pin updates take effect at most once per millisecond.
// - generic zero drives pin low; one releases it to the pull-up.
// - pins owned by a function are left out of input change reports.
// - bit 7 of the two-wire flags byte disables its pull-ups.
package spm_pkg;
  localparam int PINS = 56;
  localparam int KEY_LINES = 8;
  localparam int ROW_W = 3;
  localparam int KEY_COUNT = 64;
  // word bases of each port
  localparam int PORT0_BASE = 0;
  localparam int PORT1_BASE = 8;
  localparam int PORT2_BASE = 16;
  localparam int PORT3_BASE = 24;
  localparam int PORT4_BASE = 32;
  localparam int PORT5_BASE = 40;
  // pins that exist: bits 0..48 and 55
  localparam logic [PINS-1:0] PIN_VALID = 56'h81_FFFF_FFFF_FFFF;
  // two-wire pins and flag position
  localparam int TW_SCL = PORT1_BASE + 7;
  localparam int TW_SDA = PORT1_BASE + 5;
  localparam int TW_NOPULL_BIT = 7;
  // display pins
  localparam int DISP_POWER = PORT4_BASE + 0;
  localparam int DISP_RSEL = PORT4_BASE + 1;
  localparam int DISP_RW = PORT4_BASE + 2;
  localparam int DISP_EN = PORT4_BASE + 3;
  localparam int DISP_EN2 = PORT4_BASE + 4;
  localparam int DISP_DATA = PORT3_BASE;
  // serial peripheral pins
  localparam int PER_SCK = PORT5_BASE + 0;
  localparam int PER_SEL = PORT5_BASE + 1;
  localparam int PER_MOSI = PORT5_BASE + 2;
  localparam int PER_RDY = PORT5_BASE + 3;
  localparam int PER_MISO = PORT5_BASE + 4;
  // led shifter pins
  localparam int LED_DATA = PORT1_BASE + 0;
  localparam int LED_CLK = PORT1_BASE + 1;
  localparam int LED_STRB = PORT1_BASE + 2;
  localparam int LED_OE = PORT1_BASE + 3;
  // key matrix lines
  localparam int KEY_ROW = PORT0_BASE;
  localparam int KEY_COL = PORT2_BASE;
  // reset values
  localparam logic [PINS-1:0] RST_GEN_OUT = 56'hFF_FFFF_FFFF_FFFF;
  localparam logic [PINS-1:0] RST_OUT = 56'h00_0000_0000_0000;
  localparam logic [PINS-1:0] RST_OE_N = 56'hFF_FFFF_FFFF_FFFF;
  localparam logic [PINS-1:0] RST_PULL = PIN_VALID;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PERIOD_PS = 1_000_000_000;
  localparam int MS_CYCLES = MS_PERIOD_PS / CLK_PERIOD_PS;
  localparam int SCAN_PERIOD_MS = 4;
  localparam int DEBOUNCE_MS = 16;
  localparam int ROW_STEP_CYCLES = SCAN_PERIOD_MS * MS_CYCLES / KEY_LINES;
  localparam int DEBOUNCE_SCANS = DEBOUNCE_MS / SCAN_PERIOD_MS;
endpackage

// ===== src/spm_key_scan.sv
// Purpose: 8x8 key matrix row walker and per-key debouncer
// Assumes: columns already synchronised, closed key reads low
// Notes: a key flips after DEBOUNCE_SCANS disagreeing scans in a row
`timescale 1ns/1ps
module spm_key_scan #(
  parameter int ROW_STEP_CYCLES = spm_pkg::ROW_STEP_CYCLES, // row slot
  parameter int DEBOUNCE_SCANS = spm_pkg::DEBOUNCE_SCANS // scans to agree
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scanEnable, // key mode on and not suspended
  input wire logic [spm_pkg::KEY_LINES-1:0] colSync, // column levels
  output logic [spm_pkg::KEY_LINES-1:0] rowActive, // row pulled low
  output logic [spm_pkg::KEY_COUNT-1:0] keyState, // 1 = key closed
  output logic keyChange // pulse when a key flips
);
  import spm_pkg::*;
  localparam int SW = $clog2(ROW_STEP_CYCLES);
  localparam int DW = $clog2(DEBOUNCE_SCANS + 1);
  logic [SW-1:0] stepCnt;
  logic [ROW_W-1:0] rowIdx;
  logic [KEY_COUNT-1:0] flip;
  wire stepEnd = (stepCnt == SW'(ROW_STEP_CYCLES - 1));

  // row slot timer: eight slots make one full scan
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stepCnt <= '0;
      rowIdx <= '0;
    end else if (!scanEnable) begin
      stepCnt <= '0;
      rowIdx <= '0;
    end else if (stepEnd) begin
      stepCnt <= '0;
      rowIdx <= rowIdx + 1'b1;
    end else begin
      stepCnt <= stepCnt + 1'b1;
    end
  end

  // exactly one row low at a time while scanning
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rowActive <= '0;
      keyChange <= 1'b0;
    end else begin
      rowActive <= scanEnable ? (KEY_LINES'(1) << rowIdx) : '0;
      keyChange <= |flip;
    end
  end

  // per-key debounce, sampled at the end of its row slot
  for (genvar k = 0; k < KEY_COUNT; k++) begin : g_key
    logic [DW-1:0] agree;
    logic state;
    wire raw = ~colSync[k % KEY_LINES];
    wire sampleHere = scanEnable & stepEnd
                      & (rowIdx == ROW_W'(k / KEY_LINES));
    assign flip[k] = sampleHere & (raw != state)
                     & (agree == DW'(DEBOUNCE_SCANS - 1));
    assign keyState[k] = state;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        agree <= '0;
        state <= 1'b0;
      end else if (!scanEnable) begin
        agree <= '0;
        state <= 1'b0;
      end else if (sampleHere) begin
        if (raw == state) begin
          agree <= '0;
        end else if (flip[k]) begin
          agree <= '0;
          state <= raw;
        end else begin
          agree <= agree + 1'b1;
        end
      end
    end
  end

  a_row_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(scanEnable) |-> $onehot(rowActive))
    else $error("key rows not driven one at a time");
  c_key_flip: cover property (@(posedge clk_sys) disable iff (!rst_n)
    keyChange);
endmodule

// ===== src/spm_pin_mux.sv
// Purpose: pin ownership and driver modes for the 56-bit port word
// Assumes: function engines and report logic run on clk_sys
// Notes: pins are modelled as out, active-low enable and pull-up
`timescale 1ns/1ps
module spm_pin_mux #(
  parameter int MS_CYCLES = spm_pkg::MS_CYCLES, // cycles per report slot
  parameter int ROW_STEP_CYCLES = spm_pkg::ROW_STEP_CYCLES // key row slot
) (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst_n, // async reset, active low
  // generic port access
  input wire logic [spm_pkg::PINS-1:0] genWordIn, // host output word
  input wire logic genWrite, // pulse: new output word
  output logic [spm_pkg::PINS-1:0] genInWord, // last reported input
  output logic genInChange, // pulse: new input report
  output logic wakeRequest, // pulse: pin change in suspend
  input wire logic suspend, // bus suspended, level
  // two-wire master engine
  input wire logic twoWireEnable, // function on
  input wire logic [7:0] twoWireFlags, // enable command flags
  input wire logic twSclLow, // pull clock line low
  input wire logic twSdaLow, // pull data line low
  output logic twSclIn, // clock line level
  output logic twSdaIn, // data line level
  // display bus engine
  input wire logic displayEnable, // function on
  input wire logic displayNoPull, // drop display pull-ups
  input wire logic dispRegSelect, // register select
  input wire logic dispReadWrite, // read/write line
  input wire logic dispEnStrobe, // enable strobe
  input wire logic dispEnSecond, // second enable
  input wire logic [7:0] dispDataOut, // data to display
  input wire logic dispDataDrive, // drive data bus
  output logic [7:0] dispDataIn, // data from display
  // serial peripheral engine
  input wire logic periphEnable, // function on
  input wire logic periphOpenDrain, // low-voltage pin option
  input wire logic perSck, // data clock
  input wire logic perSelect_n, // slave select
  input wire logic perMosi, // data out
  output logic perMiso, // data in
  output logic perDataReady_n, // data ready input
  // led matrix shifter engine
  input wire logic ledEnable, // function on
  input wire logic ledOutEnable_n, // driver enable
  input wire logic ledStrobe, // latch strobe
  input wire logic ledShiftClk, // shift clock
  input wire logic ledShiftData, // shift data
  // key matrix scanner
  input wire logic keyEnable, // function on
  output logic [spm_pkg::KEY_COUNT-1:0] keyState, // debounced keys
  output logic keyChange, // pulse: key flipped
  // pin side
  input wire logic [spm_pkg::PINS-1:0] pinIn, // pin levels
  output logic [spm_pkg::PINS-1:0] pinOut, // pin drive value
  output logic [spm_pkg::PINS-1:0] pinOe_n, // pin driver on, low
  output logic [spm_pkg::PINS-1:0] pinPullUp // pull-up on, high
);
  import spm_pkg::*;
  localparam int MSW = $clog2(MS_CYCLES);

  logic [PINS-1:0] pinMeta, pinSync;
  logic [MSW-1:0] msCnt;
  logic msTick;
  logic [PINS-1:0] genOut, genPend;
  logic pendValid;
  logic [PINS-1:0] fnOwn, fnOut, fnOeN, fnPull;
  logic [KEY_LINES-1:0] rowActive;

  // two-stage synchroniser on every pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= RST_GEN_OUT;
      pinSync <= RST_GEN_OUT;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // one millisecond slot tick
  wire msWrap = (msCnt == MSW'(MS_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msCnt <= '0;
      msTick <= 1'b0;
    end else begin
      msCnt <= msWrap ? '0 : msCnt + 1'b1;
      msTick <= msWrap;
    end
  end

  // output word: newest write waits for the next slot
  wire applyPend = msTick & pendValid;
  wire next_pendValid = genWrite | (pendValid & ~msTick);
  wire [PINS-1:0] next_genOut = (applyPend ? genPend : genOut)
                                | fnOwn;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      genPend <= RST_GEN_OUT;
      pendValid <= 1'b0;
      genOut <= RST_GEN_OUT;
    end else begin
      if (genWrite) begin
        genPend <= genWordIn;
      end
      pendValid <= next_pendValid;
      genOut <= next_genOut;
    end
  end

  // function ownership and driver modes, disjoint pin groups
  wire perOd = periphOpenDrain;
  always_comb begin
    fnOwn = '0;
    fnOut = '0;
    fnOeN = '1;
    fnPull = '1;
    if (twoWireEnable) begin
      fnOwn[TW_SCL] = 1'b1;
      fnOwn[TW_SDA] = 1'b1;
      fnOeN[TW_SCL] = ~twSclLow;
      fnOeN[TW_SDA] = ~twSdaLow;
      fnPull[TW_SCL] = ~twoWireFlags[TW_NOPULL_BIT];
      fnPull[TW_SDA] = ~twoWireFlags[TW_NOPULL_BIT];
    end
    if (displayEnable) begin
      for (int i = 0; i < 8; i++) begin
        fnOwn[DISP_DATA + i] = 1'b1;
        fnOut[DISP_DATA + i] = dispDataOut[i];
        fnOeN[DISP_DATA + i] = ~dispDataDrive;
        fnPull[DISP_DATA + i] = ~displayNoPull;
      end
      for (int i = DISP_POWER; i <= DISP_EN2; i++) begin
        fnOwn[i] = 1'b1;
        fnOeN[i] = 1'b0;
        fnPull[i] = ~displayNoPull;
      end
      fnOut[DISP_POWER] = 1'b0;
      fnOut[DISP_RSEL] = dispRegSelect;
      fnOut[DISP_RW] = dispReadWrite;
      fnOut[DISP_EN] = dispEnStrobe;
      fnOut[DISP_EN2] = dispEnSecond;
      // chip selects on port four bits 5,6 are left to the generic word
      fnOwn[PORT4_BASE + 5] = 1'b0;
      fnOwn[PORT4_BASE + 6] = 1'b0;
    end
    if (periphEnable) begin
      for (int i = PER_SCK; i <= PER_MISO; i++) begin
        fnOwn[i] = 1'b1;
      end
      // push-pull by default, open drain in the low-voltage option
      fnOut[PER_SCK] = perOd ? 1'b0 : perSck;
      fnOeN[PER_SCK] = perOd ? perSck : 1'b0;
      fnPull[PER_SCK] = 1'b0;
      fnOut[PER_MOSI] = perOd ? 1'b0 : perMosi;
      fnOeN[PER_MOSI] = perOd ? perMosi : 1'b0;
      fnPull[PER_MOSI] = 1'b0;
      fnOeN[PER_SEL] = perSelect_n;
      fnPull[PER_SEL] = ~perOd;
      fnPull[PER_RDY] = ~perOd;
      fnPull[PER_MISO] = 1'b0;
    end
    if (ledEnable) begin
      for (int i = LED_DATA; i <= LED_OE; i++) begin
        fnOwn[i] = 1'b1;
        fnOeN[i] = 1'b0;
        fnPull[i] = 1'b0;
      end
      fnOut[LED_DATA] = ledShiftData;
      fnOut[LED_CLK] = ledShiftClk;
      fnOut[LED_STRB] = ledStrobe;
      fnOut[LED_OE] = ledOutEnable_n;
    end
    if (keyEnable) begin
      for (int i = 0; i < KEY_LINES; i++) begin
        fnOwn[KEY_ROW + i] = 1'b1;
        fnOeN[KEY_ROW + i] = ~rowActive[i];
        fnPull[KEY_ROW + i] = 1'b0;
        fnOwn[KEY_COL + i] = 1'b1;
      end
    end
  end

  // suspend: release and pull every pin, hold power and led enable high
  wire [PINS-1:0] suspHigh = ({{(PINS-1){1'b0}}, displayEnable}
                              << DISP_POWER)
                             | ({{(PINS-1){1'b0}}, ledEnable}
                              << LED_OE);
  // generic pins are open drain: zero drives low, one releases
  wire [PINS-1:0] genOeN = genOut;
  wire [PINS-1:0] next_pinOut = suspend ? suspHigh : (fnOwn & fnOut);
  wire [PINS-1:0] next_pinOeN = (suspend ? ~suspHigh
                                 : ((fnOwn & fnOeN) | (~fnOwn & genOeN)))
                                | ~PIN_VALID;
  wire [PINS-1:0] next_pinPull = (suspend ? PIN_VALID
                                  : ((fnOwn & fnPull) | ~fnOwn))
                                 & PIN_VALID;

  // pin drivers, registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= RST_OUT;
      pinOe_n <= RST_OE_N;
      pinPullUp <= RST_PULL;
    end else begin
      pinOut <= next_pinOut;
      pinOe_n <= next_pinOeN;
      pinPullUp <= next_pinPull;
    end
  end

  // readback for the function engines
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      twSclIn <= 1'b1;
      twSdaIn <= 1'b1;
      dispDataIn <= '0;
      perMiso <= 1'b0;
      perDataReady_n <= 1'b1;
    end else begin
      twSclIn <= pinSync[TW_SCL];
      twSdaIn <= pinSync[TW_SDA];
      dispDataIn <= pinSync[DISP_DATA +: 8];
      perMiso <= pinSync[PER_MISO];
      perDataReady_n <= pinSync[PER_RDY];
    end
  end

  // input report: owned and absent bits read as one
  wire [PINS-1:0] keyOwn = keyEnable ? {{(PINS-24){1'b0}}, 8'hFF, 8'h00,
                                        8'hFF} : '0;
  wire [PINS-1:0] inSample = pinSync | fnOwn | ~PIN_VALID;
  wire inDiffers = (inSample != genInWord);
  wire wakeDiffers = ((inSample ^ genInWord) & ~keyOwn) != '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      genInWord <= RST_GEN_OUT;
      genInChange <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      genInChange <= msTick & inDiffers & ~suspend;
      wakeRequest <= msTick & wakeDiffers & suspend;
      if (msTick & inDiffers) begin
        genInWord <= inSample;
      end
    end
  end

  // key matrix scanning and debounce
  spm_key_scan #(
    .ROW_STEP_CYCLES(ROW_STEP_CYCLES),
    .DEBOUNCE_SCANS(DEBOUNCE_SCANS)
  ) u_keys (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scanEnable(keyEnable & ~suspend),
    .colSync(pinSync[KEY_COL +: KEY_LINES]),
    .rowActive(rowActive),
    .keyState(keyState),
    .keyChange(keyChange)
  );

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_gen_ignore_write: assert property (
    !$past(msTick) |-> genOut == ($past(genOut) | $past(fnOwn)))
    else $error("output word changed outside a slot");
  a_gen_open_drain: assert property (
    !suspend && !keyEnable && !ledEnable && !twoWireEnable
    |=> pinOe_n[PORT1_BASE +: 8] == $past(genOut[PORT1_BASE +: 8])
        && pinOut[PORT1_BASE +: 8] == 8'h00)
    else $error("generic pin not open drain");
  a_tw_drive: assert property (
    twoWireEnable && !suspend
    |=> !pinOut[TW_SCL] && pinOe_n[TW_SCL] == !$past(twSclLow)
        && pinOe_n[TW_SDA] == !$past(twSdaLow))
    else $error("two-wire pin drive wrong");
  a_tw_pull_off: assert property (
    twoWireEnable && !suspend && twoWireFlags[7]
    |=> !pinPullUp[TW_SCL] && !pinPullUp[TW_SDA])
    else $error("two-wire pull-up not dropped");
  a_disp_power: assert property (
    displayEnable |=> pinOut[DISP_POWER] == $past(suspend)
                      && !pinOe_n[DISP_POWER])
    else $error("display power line wrong");
  a_led_oe_susp: assert property (
    (ledEnable && suspend) [*2] |-> pinOut[LED_OE] && !pinOe_n[LED_OE])
    else $error("led enable not high in suspend");
  a_per_default: assert property (
    periphEnable && !periphOpenDrain && !suspend
    |=> !pinOe_n[PER_SCK] && pinPullUp[PER_SEL] && pinPullUp[PER_RDY]
        && pinOe_n[PER_MISO] && !pinPullUp[PER_MISO])
    else $error("peripheral default pin modes wrong");
  a_key_susp_pull: assert property (
    suspend |=> (&pinPullUp[KEY_COL +: 8]) && (&pinPullUp[KEY_ROW +: 8])
                && (&pinOe_n[KEY_ROW +: 8]) && !genInChange)
    else $error("key lines not released in suspend");
  a_in_masked: assert property (
    genInChange |-> (genInWord & $past(fnOwn)) == $past(fnOwn))
    else $error("owned pin reported as input");

  c_tw_active: cover property (twoWireEnable && twSclLow ##1 !pinOe_n[TW_SCL]);
  c_in_report: cover property (genInChange);
  c_wake: cover property (wakeRequest);
endmodule

// ===== verification/spm_far_side.sv
// Purpose: pin-side model of the chips and key matrix around the pin mux
// Assumes: one level per pin, resolved from device drive, pulls and outside
// Notes: a released pin with no pull shows a level that flips every cycle
`timescale 1ns/1ps
module spm_far_side (
  input wire logic clk_sys, // system clock
  input wire logic [spm_pkg::PINS-1:0] pinOut, // device drive value
  input wire logic [spm_pkg::PINS-1:0] pinOe_n, // device driver on, low
  input wire logic [spm_pkg::PINS-1:0] pinPullUp, // device pull-up on
  input wire logic [spm_pkg::PINS-1:0] extLow, // outside chip pulls low
  input wire logic [63:0] keyDown, // closed keys, row*8+col
  output logic [spm_pkg::PINS-1:0] pinIn // resolved pin levels
);
  import spm_pkg::*;
  logic flip = 1'b0;
  // floating lines never keep a stale level
  always_ff @(posedge clk_sys) begin
    flip <= ~flip;
  end
  // wire resolution, then keys pull columns down onto low rows
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!pinOe_n[i]) pinIn[i] = pinOut[i];
      else if (extLow[i]) pinIn[i] = 1'b0;
      else if (pinPullUp[i]) pinIn[i] = 1'b1;
      else pinIn[i] = flip;
    end
    for (int k = 0; k < KEY_COUNT; k++) begin
      if (keyDown[k] && !pinOe_n[KEY_ROW + k / 8]
          && !pinOut[KEY_ROW + k / 8]) begin
        pinIn[KEY_COL + k % 8] = 1'b0;
      end
    end
  end
endmodule

// ===== verification/spm_pin_mux_tb_top.sv
// Purpose: self-checking bench for the special function pin multiplexer
// Assumes: short report slot and key row slot parameters
// Notes: drivers queue expectations, a negedge monitor compares them
`timescale 1ns/1ps
module spm_pin_mux_tb_top;
  import spm_pkg::*;
  localparam int MS = 40;
  localparam int RS = 8;
  logic clk_sys, rst_n, genWrite, genInChange, wakeRequest, suspend;
  logic twoWireEnable, twSclLow, twSdaLow, twSclIn, twSdaIn;
  logic displayEnable, displayNoPull, dispRegSelect, dispReadWrite;
  logic dispEnStrobe, dispEnSecond, dispDataDrive, periphEnable;
  logic periphOpenDrain, perSck, perSelect_n, perMosi, perMiso;
  logic perDataReady_n, ledEnable, ledOutEnable_n, ledStrobe;
  logic ledShiftClk, ledShiftData, keyEnable, keyChange;
  logic [7:0] twoWireFlags, dispDataOut, dispDataIn;
  logic [PINS-1:0] genWordIn, genInWord, pinIn, pinOut, pinOe_n;
  logic [PINS-1:0] pinPullUp, extLow, w;
  logic [31:0] rA, rB;
  logic [63:0] keyState, keyDown;
  typedef struct {int sel; logic [63:0] mask; logic [63:0] exp;} spm_note_t;
  spm_note_t notes[$];
  spm_note_t n;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'd22;

  spm_pin_mux #(.MS_CYCLES(MS), .ROW_STEP_CYCLES(RS)) spm_pin_mux_i (.*);
  spm_far_side spm_far_side_i (.clk_sys(clk_sys), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .pinPullUp(pinPullUp), .extLow(extLow),
    .keyDown(keyDown), .pinIn(pinIn));

  // clock at 200 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [63:0] obs(input int s);
    case (s)
      0: obs = {8'h00, pinOe_n};
      1: obs = {8'h00, pinPullUp};
      2: obs = {8'h00, pinOut};
      3: obs = {8'h00, genInWord};
      4: obs = keyState;
      default: obs = {52'h0, perDataReady_n, perMiso, dispDataIn, twSdaIn,
                      twSclIn};
    endcase
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input int s, input logic [63:0] m, input logic [63:0] e);
    notes.push_back('{s, m, e});
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // bounded wait for a report or key pulse
  task automatic waitPulse(input bit key, input int lim);
    int k;
    k = 0;
    while (((key ? keyChange : genInChange) !== 1'b1) && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= lim) check(64'h0, 64'h1);
    @(posedge clk_sys);
  endtask

  task automatic genPut(input logic [PINS-1:0] v);
    genWordIn <= v;
    genWrite <= 1'b1;
    tick(1);
    genWrite <= 1'b0;
    tick(MS + 3);
  endtask

  task automatic close_out();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // monitor: every queued note, oldest first, against the settled outputs
  initial begin
    forever begin
      @(negedge clk_sys);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        check(obs(n.sel) & n.mask, n.exp);
      end
    end
  end

  // watchdog
  initial begin
    #100000;
    bad_count++;
    close_out();
  end

  initial begin
    {genWrite, suspend, twoWireEnable, twSclLow, twSdaLow} = '0;
    {displayEnable, displayNoPull, dispRegSelect, dispReadWrite} = '0;
    {dispEnStrobe, dispEnSecond, dispDataDrive, periphEnable} = '0;
    {periphOpenDrain, perSck, perMosi, ledEnable, keyEnable} = '0;
    {ledStrobe, ledShiftClk, ledShiftData} = '0;
    perSelect_n = 1'b1;
    ledOutEnable_n = 1'b1;
    twoWireFlags = 8'h00;
    dispDataOut = 8'h00;
    genWordIn = '1;
    extLow = '0;
    keyDown = '0;
    rst_n = 1'b0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    note(0, '1, {8'h00, RST_OE_N});
    note(1, '1, {8'h00, PIN_VALID});
    note(3, '1, {8'h00, {PINS{1'b1}}});
    tick(2);
    $display("test reset done");
    // outside chip pulls port two pin 4 low
    extLow[20] <= 1'b1;
    waitPulse(1'b0, 3 * MS);
    note(3, '1, 64'h00FF_FFFF_FFEF_FFFF);
    extLow[20] <= 1'b0;
    waitPulse(1'b0, 3 * MS);
    $display("test input report done");
    // random generic word, unused port six bits written as one
    rA = rnd();
    rB = rnd();
    w = {rA[23:0], rB} | 56'h7E_0000_0000_0000;
    genPut(w);
    note(0, '1, {8'h00, w | ~PIN_VALID});
    note(2, '1, 64'h0);
    $display("test generic write done");
    // two-wire owns its pins; generic zeros must not reach them
    twoWireFlags <= 8'h80;
    twoWireEnable <= 1'b1;
    genPut('0);
    note(0, '1, {8'h00, ~PIN_VALID} | 64'hA000);
    note(1, 64'hA000, 64'h0);
    twSclLow <= 1'b1;
    twSdaLow <= 1'b1;
    tick(5);
    note(0, 64'hA000, 64'h0);
    note(5, 64'h3, 64'h0);
    {twSclLow, twSdaLow, twoWireEnable} <= '0;
    twoWireFlags <= 8'h00;
    genPut('1);
    $display("test two-wire done");
    // display and led shifter, then suspend
    {displayEnable, displayNoPull, dispDataDrive} <= '1;
    {dispRegSelect, dispReadWrite, dispEnSecond} <= '1;
    dispDataOut <= 8'hA5;
    {ledEnable, ledStrobe, ledShiftClk, ledShiftData} <= '1;
    ledOutEnable_n <= 1'b0;
    tick(3);
    note(2, 64'h1F_FF00_0F00, 64'h16_A500_0700);
    note(0, 64'h1_0000_0800, 64'h0);
    note(1, 64'h1E_FF00_0000, 64'h0);
    suspend <= 1'b1;
    tick(3);
    note(2, 64'h1_0000_0800, 64'h1_0000_0800);
    suspend <= 1'b0;
    {displayEnable, ledEnable} <= '0;
    tick(3);
    $display("test display led done");
    // serial peripheral, default drivers then the low-voltage option
    {periphEnable, perSck} <= '1;
    tick(3);
    note(0, 64'h1F00_0000_0000, 64'h1A00_0000_0000);
    note(2, 64'h0500_0000_0000, 64'h0100_0000_0000);
    note(1, 64'h1F00_0000_0000, 64'h0A00_0000_0000);
    periphOpenDrain <= 1'b1;
    tick(3);
    note(0, 64'h1F00_0000_0000, 64'h1B00_0000_0000);
    note(1, 64'h1F00_0000_0000, 64'h0);
    {periphEnable, periphOpenDrain} <= '0;
    tick(3);
    $display("test peripheral done");
    // key matrix: row 2 column 5 closed
    keyEnable <= 1'b1;
    keyDown[21] <= 1'b1;
    waitPulse(1'b1, 1000);
    note(4, '1, 64'h1 << 21);
    note(1, 64'hFF_FFFF, 64'hFF_FF00);
    suspend <= 1'b1;
    tick(3);
    note(1, 64'hFF_FFFF, 64'hFF_FFFF);
    note(4, '1, 64'h0);
    tick(2);
    suspend <= 1'b0;
    $display("test key matrix done");
    tick(3);
    close_out();
  end
endmodule
